// *** hw/ufm_device.sv ***
// Device end: message transmit sequencer, regular word stage, receive buffer
`timescale 1ns/1ns
module ufm_device import ufm_pkg::*; #(
  parameter bit MSG_ENABLE = UFM_MSG_ENABLE,
  parameter bit FRAMING_UI = UFM_FRAMING_UI,
  parameter bit TX_ENABLE = UFM_TX_ENABLE,
  parameter bit RX_ENABLE = UFM_RX_ENABLE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // User side
  ufm_if.dev bus,
  // Regular frame words toward the link
  output logic [UFM_DW-1:0] link_tx_tdata,
  output logic link_tx_tvalid,
  input wire logic link_tx_tready,
  // Message beats toward the link
  output logic [UFM_DW-1:0] link_msg_tdata,
  output logic link_msg_tvalid,
  output logic link_msg_tlast,
  output logic [UFM_BYTES-1:0] link_msg_tkeep,
  // Message beats from the link
  input wire logic [UFM_DW-1:0] link_rx_msg_tdata,
  input wire logic link_rx_msg_tvalid,
  input wire logic link_rx_msg_tlast,
  input wire logic [UFM_BYTES-1:0] link_rx_msg_tkeep,
  output logic link_rx_msg_tready
);

  // ----------------------------------------------------------------
  // Build options
  // ----------------------------------------------------------------
  // Sides left out stay in place as ports but never answer
  localparam bit MSG_ON = MSG_ENABLE && FRAMING_UI;
  localparam bit TX_ON = MSG_ON && TX_ENABLE;
  localparam bit RX_ON = MSG_ON && RX_ENABLE;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // One message owns the user data bus for the acknowledge cycle and one
  // cycle per beat; each beat leaves on the link a cycle after it is read
  typedef struct packed {
    ufm_tx_state_t st;
    logic [UFM_CODE_W-1:0] code;
    logic [1:0] beat;
    logic [UFM_DW-1:0] ltx_data;
    logic ltx_valid;
    logic [UFM_DW-1:0] msg_data;
    logic msg_valid;
    logic msg_last;
    logic [UFM_BYTES-1:0] msg_keep;
    logic [UFM_BUF_DEPTH-1:0][UFM_DW-1:0] buf_data;
    logic [UFM_BUF_DEPTH-1:0][UFM_BYTES-1:0] buf_keep;
    logic [UFM_BUF_DEPTH-1:0] buf_last;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } ufm_dev_state_t;

  ufm_dev_state_t cur;
  ufm_dev_state_t next_cur;

  logic is_last_beat;
  logic [UFM_BYTES-1:0] beat_keep;
  logic [UFM_DW-1:0] beat_data;
  logic rx_push;
  logic rx_pop;
  logic tx_take;
  logic msg_active;
  logic word_take;
  logic word_drain;
  logic buf_full;
  logic buf_empty;
  logic [1:0] last_beat;
  logic [UFM_BYTES-1:0] last_keep;
  logic [1:0] next_count;

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  // A request is taken only by the idle sequencer of a built transmit side
  assign tx_take = TX_ON && (cur.st == UFM_TX_IDLE) && bus.tx_req;
  // The acknowledge cycle and every beat cycle own the user data bus
  assign msg_active = (cur.st != UFM_TX_IDLE);
  assign word_take = bus.tx_tvalid && bus.tx_tready;
  assign word_drain = cur.ltx_valid && link_tx_tready;
  assign buf_full = (cur.count == 2'(UFM_BUF_DEPTH));
  assign buf_empty = (cur.count == 2'h0);
  assign last_beat = ufm_last_beat(cur.code);
  assign last_keep = ufm_last_keep(cur.code);
  // Occupancy after this cycle's push and pop
  assign next_count = cur.count + {1'b0, rx_push} - {1'b0, rx_pop};

  // ----------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------
  assign bus.tx_ack = TX_ON && (cur.st == UFM_TX_ACK);
  // Regular words stall from acknowledge through the final message beat
  assign bus.tx_tready = !msg_active && (!cur.ltx_valid || link_tx_tready);
  assign link_rx_msg_tready = RX_ON && !buf_full;
  assign rx_push = link_rx_msg_tvalid && link_rx_msg_tready;
  assign rx_pop = bus.rx_tvalid && bus.rx_tready;

  // ----------------------------------------------------------------
  // Lane masking of the current message beat
  // ----------------------------------------------------------------
  assign is_last_beat = (cur.beat == last_beat);
  assign beat_keep = is_last_beat ? last_keep : UFM_KEEP_FULL;

  // Lanes past the end of the message go out as zero
  for (genvar lane = 0; lane < UFM_BYTES; lane++) begin : g_lane
    assign beat_data[lane*8 +: 8] = beat_keep[lane] ? bus.tx_tdata[lane*8 +: 8] : 8'h00;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.msg_valid = 1'b0;
    next_cur.msg_last = 1'b0;
    // --------------------------------------------------------------
    // Message sequencer
    // --------------------------------------------------------------
    case (cur.st)
      UFM_TX_IDLE: begin
        if (tx_take) begin
          next_cur.st = UFM_TX_ACK;
          next_cur.code = bus.msg_tx_size_code;
          next_cur.beat = 2'h0;
        end
      end
      UFM_TX_ACK: begin
        next_cur.st = UFM_TX_DATA;
      end
      UFM_TX_DATA: begin
        next_cur.msg_valid = 1'b1;
        next_cur.msg_data = beat_data;
        next_cur.msg_keep = beat_keep;
        if (is_last_beat) begin
          next_cur.msg_last = 1'b1;
          next_cur.st = UFM_TX_IDLE;
        end else begin
          next_cur.beat = cur.beat + 2'h1;
        end
      end
      default: begin
        next_cur.st = UFM_TX_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // Regular word stage
    // --------------------------------------------------------------
    if (word_drain) begin
      next_cur.ltx_valid = 1'b0;
    end
    if (word_take) begin
      next_cur.ltx_valid = 1'b1;
      next_cur.ltx_data = bus.tx_tdata;
    end

    // --------------------------------------------------------------
    // Receive buffer
    // --------------------------------------------------------------
    if (rx_push) begin
      next_cur.buf_data[cur.wr_ptr] = link_rx_msg_tdata;
      next_cur.buf_keep[cur.wr_ptr] = link_rx_msg_tkeep;
      next_cur.buf_last[cur.wr_ptr] = link_rx_msg_tlast;
      next_cur.wr_ptr = ~cur.wr_ptr;
    end
    if (rx_pop) begin
      next_cur.rd_ptr = ~cur.rd_ptr;
    end
    next_cur.count = next_count;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      // Buffer empties and the sequencer parks idle
      cur <= '0;
      cur.st <= UFM_TX_IDLE;
      cur.code <= UFM_CODE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link_tx_tdata = cur.ltx_data;
  assign link_tx_tvalid = cur.ltx_valid;
  assign link_msg_tdata = cur.msg_data;
  assign link_msg_tvalid = cur.msg_valid;
  assign link_msg_tlast = cur.msg_last;
  assign link_msg_tkeep = cur.msg_keep;

  // ----------------------------------------------------------------
  // Receive stream outputs
  // ----------------------------------------------------------------
  assign bus.rx_tvalid = !buf_empty;
  assign bus.rx_tdata = cur.buf_data[cur.rd_ptr];
  assign bus.rx_tlast = cur.buf_last[cur.rd_ptr];
  assign bus.rx_tkeep = cur.buf_keep[cur.rd_ptr];

endmodule: ufm_device

// *** hw/ufm_pkg.sv ***
// Shared constants and types for the user flow message port, both ends
package ufm_pkg;

  // ----------------------------------------------------------------
  // Widths and build options
  // ----------------------------------------------------------------
  localparam int unsigned UFM_BYTES = 4;
  localparam int unsigned UFM_DW = 8 * UFM_BYTES;
  localparam int unsigned UFM_CODE_W = 3;
  localparam int unsigned UFM_MSG_MAX_BYTES = 16;
  localparam int unsigned UFM_MAX_BEATS = UFM_MSG_MAX_BYTES / UFM_BYTES;
  localparam int unsigned UFM_BUF_DEPTH = 2;
  localparam bit UFM_MSG_ENABLE = 1'b1;
  localparam bit UFM_FRAMING_UI = 1'b1;
  localparam bit UFM_TX_ENABLE = 1'b1;
  localparam bit UFM_RX_ENABLE = 1'b1;

  // ----------------------------------------------------------------
  // Byte-keep values and reset values
  // ----------------------------------------------------------------
  localparam logic [UFM_BYTES-1:0] UFM_KEEP_FULL = 4'hf;
  localparam logic [UFM_BYTES-1:0] UFM_KEEP_HALF = 4'h3;
  localparam logic [UFM_CODE_W-1:0] UFM_CODE_RESET = 3'h0;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UFM_TX_IDLE = 3'b001,
    UFM_TX_ACK = 3'b010,
    UFM_TX_DATA = 3'b100
  } ufm_tx_state_t;

  typedef enum logic [2:0] {
    UFM_U_IDLE = 3'b001,
    UFM_U_REQ = 3'b010,
    UFM_U_DATA = 3'b100
  } ufm_usr_state_t;

  // ----------------------------------------------------------------
  // Size code helpers
  // ----------------------------------------------------------------
  // Index of the final beat: ceil(2*(code+1)/4)-1 on a 4-byte bus
  function automatic logic [1:0] ufm_last_beat(input logic [UFM_CODE_W-1:0] code);
    ufm_last_beat = code[2:1];
  endfunction: ufm_last_beat

  // Even codes end on a 2-byte beat, odd codes on a full beat
  function automatic logic [UFM_BYTES-1:0] ufm_last_keep(input logic [UFM_CODE_W-1:0] code);
    ufm_last_keep = code[0] ? UFM_KEEP_FULL : UFM_KEEP_HALF;
  endfunction: ufm_last_keep

endpackage: ufm_pkg

// *** hw/ufm_if.sv ***
// Interface joining the device end and the user end of the message port
`timescale 1ns/1ns
interface ufm_if;
  import ufm_pkg::*;

  logic tx_req;
  logic [UFM_CODE_W-1:0] msg_tx_size_code;
  logic tx_ack;
  logic [UFM_DW-1:0] tx_tdata;
  logic tx_tvalid;
  logic tx_tready;
  logic [UFM_DW-1:0] rx_tdata;
  logic rx_tvalid;
  logic rx_tlast;
  logic [UFM_BYTES-1:0] rx_tkeep;
  logic rx_tready;

  modport dev (
    input tx_req, msg_tx_size_code, tx_tdata, tx_tvalid, rx_tready,
    output tx_ack, tx_tready, rx_tdata, rx_tvalid, rx_tlast, rx_tkeep
  );

  modport usr (
    output tx_req, msg_tx_size_code, tx_tdata, tx_tvalid, rx_tready,
    input tx_ack, tx_tready, rx_tdata, rx_tvalid, rx_tlast, rx_tkeep
  );

endinterface: ufm_if

// *** hw/ufm_user.sv ***
// User end: message staging and request sequencer, regular word stage, receive pass
`timescale 1ns/1ns
module ufm_user import ufm_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Device side
  ufm_if.usr bus,
  // Message submission
  input wire logic usr_msg_start,
  input wire logic [UFM_CODE_W-1:0] usr_msg_code,
  input wire logic [8*UFM_MSG_MAX_BYTES-1:0] usr_msg_data,
  output logic usr_msg_busy,
  // Regular frame words
  input wire logic [UFM_DW-1:0] usr_tx_tdata,
  input wire logic usr_tx_tvalid,
  output logic usr_tx_tready,
  // Received messages
  output logic [UFM_DW-1:0] usr_rx_tdata,
  output logic usr_rx_tvalid,
  output logic usr_rx_tlast,
  output logic [UFM_BYTES-1:0] usr_rx_tkeep,
  input wire logic usr_rx_tready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ufm_usr_state_t st;
    logic [UFM_CODE_W-1:0] code;
    logic [UFM_MAX_BEATS-1:0][UFM_DW-1:0] msg;
    logic [1:0] beat;
    logic [UFM_DW-1:0] beat_out;
    logic [UFM_DW-1:0] word;
    logic word_valid;
  } ufm_usr_reg_t;

  ufm_usr_reg_t cur;
  ufm_usr_reg_t next_cur;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign bus.tx_req = (cur.st == UFM_U_REQ);
  assign bus.msg_tx_size_code = cur.code;
  assign bus.tx_tvalid = cur.word_valid;
  assign bus.tx_tdata = (cur.st == UFM_U_DATA) ? cur.beat_out : cur.word;
  assign usr_tx_tready = !cur.word_valid || bus.tx_tready;
  assign usr_msg_busy = (cur.st != UFM_U_IDLE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    case (cur.st)
      UFM_U_IDLE: begin
        // Whole message is captured on the same edge that raises the request
        if (usr_msg_start) begin
          next_cur.msg = usr_msg_data;
          next_cur.code = usr_msg_code;
          next_cur.st = UFM_U_REQ;
        end
      end
      UFM_U_REQ: begin
        if (bus.tx_ack) begin
          next_cur.beat_out = cur.msg[0];
          next_cur.beat = 2'h0;
          next_cur.st = UFM_U_DATA;
        end
      end
      UFM_U_DATA: begin
        if (cur.beat == ufm_last_beat(cur.code)) begin
          next_cur.st = UFM_U_IDLE;
        end else begin
          next_cur.beat = cur.beat + 2'h1;
          next_cur.beat_out = cur.msg[cur.beat + 2'h1];
        end
      end
      default: begin
        next_cur.st = UFM_U_IDLE;
      end
    endcase
    if (cur.word_valid && bus.tx_tready) begin
      next_cur.word_valid = 1'b0;
    end
    if (usr_tx_tvalid && usr_tx_tready) begin
      next_cur.word_valid = 1'b1;
      next_cur.word = usr_tx_tdata;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cur <= '0;
      cur.st <= UFM_U_IDLE;
      cur.code <= UFM_CODE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Receive pass-through
  // ----------------------------------------------------------------
  assign usr_rx_tdata = bus.rx_tdata;
  assign usr_rx_tvalid = bus.rx_tvalid;
  assign usr_rx_tlast = bus.rx_tlast;
  assign usr_rx_tkeep = bus.rx_tkeep;
  assign bus.rx_tready = usr_rx_tready;

endmodule: ufm_user

// *** bench/ufm_chk.sv ***
// Checker on the interface joining the device end and the user end
`timescale 1ns/1ns
module ufm_chk import ufm_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Message request side
  input wire logic tx_req,
  input wire logic [UFM_CODE_W-1:0] msg_tx_size_code,
  input wire logic tx_ack,
  input wire logic tx_tready,
  // Receive stream side
  input wire logic [UFM_DW-1:0] rx_tdata,
  input wire logic rx_tvalid,
  input wire logic rx_tlast,
  input wire logic [UFM_BYTES-1:0] rx_tkeep,
  input wire logic rx_tready
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_ack;
    tx_ack;
  endsequence
  sequence s_gap2;
    !tx_tready ##1 !tx_tready;
  endsequence
  AST_REQ_HOLD: assert property (tx_req && !tx_ack |=> tx_req)
    else $error("request dropped before acknowledge");
  AST_CODE_HOLD: assert property (tx_req && !tx_ack |=> $stable(msg_tx_size_code))
    else $error("size code changed while request pending");
  AST_ACK_AFTER_REQ: assert property ($rose(tx_req) |=> s_ack)
    else $error("acknowledge late");
  AST_ACK_PULSE: assert property (s_ack |=> !tx_ack [*3])
    else $error("acknowledge not a single pulse");
  AST_REQ_DROP: assert property (s_ack |=> !tx_req [*2])
    else $error("request during message");
  AST_GAP: assert property (s_ack |-> s_gap2)
    else $error("regular ready high during message");
  AST_LONG: assert property ((s_ack and (msg_tx_size_code[2:1] == 2'h3)) |-> !tx_tready [*5])
    else $error("long message gap too short");
  AST_RX_HOLD: assert property (rx_tvalid && !rx_tready |=> rx_tvalid && $stable(rx_tdata))
    else $error("receive beat lost under stall");
  AST_RX_KEEP: assert property (rx_tvalid && rx_tlast |-> rx_tkeep[0])
    else $error("keep empty on last beat");
endmodule: ufm_chk

// *** bench/user_flow_message_port_tb.sv ***
// Random self-checking bench for both ends of the message port
`timescale 1ns/1ns
module user_flow_message_port_tb;
  import ufm_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic usr_msg_start = 1'b0;
  logic [2:0] usr_msg_code = 3'h0;
  logic [127:0] usr_msg_data = '0;
  logic usr_tx_tvalid = 1'b0;
  logic usr_rx_tready = 1'b0;
  logic link_tx_tready = 1'b1;
  logic link_rx_msg_tvalid = 1'b0;
  logic link_rx_msg_tlast = 1'b0;
  logic [3:0] link_rx_msg_tkeep = 4'h0;
  logic [31:0] usr_tx_tdata = 32'h0;
  logic [31:0] link_rx_msg_tdata = 32'h0;
  logic [31:0] usr_rx_tdata, link_tx_tdata, link_msg_tdata;
  logic [3:0] usr_rx_tkeep, link_msg_tkeep;
  logic usr_msg_busy, usr_tx_tready, usr_rx_tvalid, usr_rx_tlast;
  logic link_tx_tvalid, link_msg_tvalid, link_msg_tlast, link_rx_msg_tready;
  logic bg = 1'b0;
  logic stall = 1'b0;
  logic acc_w = 1'b0;
  logic acc_r = 1'b0;
  logic [36:0] em, er;
  logic [36:0] mq[$], rq[$];
  logic [31:0] wq[$];
  int n_errors = 0;
  int cmp_count = 0;
  always #5 core_clk = ~core_clk;
  ufm_if ufm_if_i ();
  ufm_user ufm_user_i (.core_clk(core_clk), .resetn(resetn), .bus(ufm_if_i),
    .usr_msg_start(usr_msg_start), .usr_msg_code(usr_msg_code), .usr_msg_data(usr_msg_data),
    .usr_msg_busy(usr_msg_busy), .usr_tx_tdata(usr_tx_tdata), .usr_tx_tvalid(usr_tx_tvalid),
    .usr_tx_tready(usr_tx_tready), .usr_rx_tdata(usr_rx_tdata), .usr_rx_tvalid(usr_rx_tvalid),
    .usr_rx_tlast(usr_rx_tlast), .usr_rx_tkeep(usr_rx_tkeep), .usr_rx_tready(usr_rx_tready));
  ufm_device ufm_device_i (.core_clk(core_clk), .resetn(resetn), .bus(ufm_if_i),
    .link_tx_tdata(link_tx_tdata), .link_tx_tvalid(link_tx_tvalid),
    .link_tx_tready(link_tx_tready), .link_msg_tdata(link_msg_tdata),
    .link_msg_tvalid(link_msg_tvalid), .link_msg_tlast(link_msg_tlast),
    .link_msg_tkeep(link_msg_tkeep), .link_rx_msg_tdata(link_rx_msg_tdata),
    .link_rx_msg_tvalid(link_rx_msg_tvalid), .link_rx_msg_tlast(link_rx_msg_tlast),
    .link_rx_msg_tkeep(link_rx_msg_tkeep), .link_rx_msg_tready(link_rx_msg_tready));
  ufm_chk ufm_chk_i (.core_clk(core_clk), .resetn(resetn), .tx_req(ufm_if_i.tx_req),
    .msg_tx_size_code(ufm_if_i.msg_tx_size_code), .tx_ack(ufm_if_i.tx_ack),
    .tx_tready(ufm_if_i.tx_tready), .rx_tdata(ufm_if_i.rx_tdata), .rx_tvalid(ufm_if_i.rx_tvalid),
    .rx_tlast(ufm_if_i.rx_tlast), .rx_tkeep(ufm_if_i.rx_tkeep), .rx_tready(ufm_if_i.rx_tready));
  // ----------------------------------------------------------------
  // Expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_data(input logic [2:0] c, input logic [127:0] d, input int i);
    int n;
    n = 2 * (c + 1) - 4 * i;
    exp_data = d[32*i +: 32];
    for (int k = n; k < 4; k++) exp_data[8*k +: 8] = 8'h00;
  endfunction: exp_data
  function automatic logic [3:0] exp_keep(input logic [2:0] c, input int i);
    exp_keep = (2 * (c + 1) - 4 * i >= 4) ? 4'hf : 4'h3;
  endfunction: exp_keep
  task automatic report(input logic bad, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (bad) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask: report
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    report(g !== e, g, e);
  endtask: cmp_word
  task automatic cmp_keep(input logic [3:0] g, input logic [3:0] e);
    report(g !== e, 32'(g), 32'(e));
  endtask: cmp_keep
  task automatic cmp_bit(input logic g, input logic e);
    report(g !== e, 32'(g), 32'(e));
  endtask: cmp_bit
  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask: print_verdict
  task automatic send(input logic [2:0] c);
    logic [127:0] d;
    int nb;
    int t;
    d = {$urandom, $urandom, $urandom, $urandom};
    nb = (2 * (c + 1) + 3) / 4;
    t = 0;
    while (usr_msg_busy !== 1'b0 && t < 50) begin
      @(negedge core_clk);
      t++;
    end
    if (usr_msg_busy !== 1'b0) begin
      n_errors++;
      print_verdict();
    end
    for (int i = 0; i < nb; i++) mq.push_back({i == nb - 1, exp_keep(c, i), exp_data(c, d, i)});
    usr_msg_code <= c;
    usr_msg_data <= d;
    usr_msg_start <= 1'b1;
    @(negedge core_clk) usr_msg_start <= 1'b0;
    @(negedge core_clk);
    cmp_bit(usr_msg_busy, 1'b1);
  endtask: send
  // ----------------------------------------------------------------
  // Drivers and monitors
  // ----------------------------------------------------------------
  always @(negedge core_clk) begin
    if (!usr_tx_tvalid || acc_w) begin
      usr_tx_tvalid <= bg && $urandom_range(1);
      usr_tx_tdata <= $urandom;
    end
    if (!link_rx_msg_tvalid || acc_r) begin
      link_rx_msg_tvalid <= bg && (stall || $urandom_range(1));
      link_rx_msg_tdata <= $urandom;
      link_rx_msg_tlast <= 1'($urandom_range(1));
      link_rx_msg_tkeep <= 4'hf >> $urandom_range(3);
    end
    link_tx_tready <= !bg || $urandom_range(3) != 0;
    usr_rx_tready <= !bg || (!stall && $urandom_range(1));
  end
  always @(posedge core_clk) begin
    acc_w <= usr_tx_tvalid && usr_tx_tready;
    acc_r <= link_rx_msg_tvalid && link_rx_msg_tready;
    if (resetn && usr_tx_tvalid && usr_tx_tready) wq.push_back(usr_tx_tdata);
    if (resetn && link_tx_tvalid && link_tx_tready) cmp_word(link_tx_tdata, wq.pop_front());
    if (resetn && link_rx_msg_tvalid && link_rx_msg_tready)
      rq.push_back({link_rx_msg_tlast, link_rx_msg_tkeep, link_rx_msg_tdata});
    if (resetn && usr_rx_tvalid && usr_rx_tready) begin
      er = rq.pop_front();
      cmp_word(usr_rx_tdata, er[31:0]);
      cmp_bit(usr_rx_tlast, er[36]);
      cmp_keep(usr_rx_tkeep, er[35:32]);
    end
    if (resetn && link_msg_tvalid) begin
      em = mq.pop_front();
      cmp_word(link_msg_tdata, em[31:0]);
      cmp_keep(link_msg_tkeep, em[35:32]);
      cmp_bit(link_msg_tlast, em[36]);
    end
  end
  initial begin
    void'($urandom(76));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) resetn <= 1'b1;
    cmp_bit(link_msg_tvalid, 1'b0);
    bg <= 1'b1;
    for (int i = 0; i < 24; i++) send(i < 8 ? 3'(i) : 3'($urandom_range(7)));
    stall <= 1'b1;
    repeat (12) @(negedge core_clk);
    cmp_bit(link_rx_msg_tready, 1'b0);
    cmp_bit(usr_rx_tvalid, 1'b1);
    stall <= 1'b0;
    bg <= 1'b0;
    repeat (40) @(negedge core_clk);
    cmp_word(32'(mq.size() + wq.size() + rq.size()), 32'h0);
    print_verdict();
  end
endmodule: user_flow_message_port_tb
